// >>> src/atr_pkg.sv
// constants and types for the table entry readout block
// assumes one clock domain and a plain word-wide register port
// Summary of operation
// RULE1: low word holds first 32 MAC bits
// RULE2: high word holds attributes and last MAC bits
// RULE3: words load only through scan commands
// RULE4: software trusts words only when valid/end set
// RULE5: end bit 27 set when scan ends
// RULE6: valid bit 26 cleared by scan command
// RULE7: valid set on found entry, else clear
// RULE8: non-static bit 25 is aging timer msb
// RULE9: static bit 25 overrides port state, not disabled
// RULE10: bit 24 exempts entry from aging removal
// RULE11: non-static bit 23 is aging timer lsb
// RULE12: static with bit 23 discards matching packets
// RULE13: bit 22 enables entry priority field
// RULE14: bits 21:19 priority, needs both enables
// RULE15: bits 18:16 encode associated port set
// RULE16: bits 15:0 hold last 16 MAC bits
// RULE17: scan position kept; first restarts, next resumes
package atr_pkg;
  localparam int ADDR_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_RD_LOW = 16'h1805;
  localparam logic [ADDR_W-1:0] ADDR_RD_HIGH = 16'h1806;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 16'h1807;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_STS = 16'h1810;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 16'h1811;
  localparam logic [ADDR_W-1:0] ADDR_CFG = 16'h1812;
  localparam int CMD_NEXT_BIT = 0;
  localparam int CMD_FIRST_BIT = 1;
  localparam int CMD_BUSY_BIT = 2;
  localparam int HI_EOT_BIT = 27;
  localparam int HI_VALID_BIT = 26;
  localparam int HI_ATTR_W = 26;
  localparam int IRQ_W = 2;
  localparam int IRQ_FOUND_BIT = 0;
  localparam int IRQ_EOT_BIT = 1;
  localparam int CFG_DAPRIO_BIT = 0;
  localparam logic [31:0] RD_LOW_RST = 32'h0000_0000;
  localparam logic [HI_ATTR_W-1:0] RD_HIGH_RST = 26'h000_0000;
  localparam logic [IRQ_W-1:0] IRQ_MSK_RST = 2'h0;
  localparam logic CFG_DAPRIO_RST = 1'b0;
  localparam int TBL_DEPTH_DEF = 512;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_CHECK} atr_state_t;

  // one table entry as the lookup table returns it
  typedef struct packed {
    logic used;
    logic age1Ovr;
    logic isStatic;
    logic age0Flt;
    logic prioEn;
    logic [2:0] prio;
    logic [2:0] portCode;
    logic [15:0] macHi;
    logic [31:0] macLo;
  } atr_entry_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } atr_bus_req_t;

  // forwarding view of one entry
  typedef struct packed {
    logic ageExempt;
    logic [1:0] ageTimer;
    logic override;
    logic discard;
    logic prioValid;
    logic [2:0] prio;
    logic [2:0] fwdMask;
  } atr_policy_t;
endpackage

// >>> src/atr_entry_decode.sv
// decodes one table entry into its forwarding policy
// assumes port state inputs are on the same clock as the caller
`timescale 1ns/10ps
module atr_entry_decode
  import atr_pkg::*;
(
  input atr_entry_t entry,
  input wire logic daPrioEn,
  input wire logic [2:0] portDisabled,
  input wire logic [2:0] portForwarding,
  output atr_policy_t policy
);
  logic [2:0] portMask;

  always_comb begin
    case (entry.portCode) // see RULE15
      3'b000: portMask = 3'b001;
      3'b001: portMask = 3'b010;
      3'b010: portMask = 3'b100;
      3'b100: portMask = 3'b011;
      3'b101: portMask = 3'b101;
      3'b110: portMask = 3'b110;
      3'b111: portMask = 3'b111;
      default: portMask = 3'b000; // reserved code forwards nowhere
    endcase
    policy.ageExempt = entry.isStatic; // see RULE10
    policy.ageTimer = entry.isStatic ? 2'b00 : {entry.age1Ovr, entry.age0Flt}; // see RULE8 RULE11
    policy.override = entry.isStatic & entry.age1Ovr; // see RULE9
    policy.discard = entry.isStatic & entry.age0Flt; // see RULE12
    policy.prioValid = entry.prioEn & daPrioEn; // see RULE13 RULE14
    policy.prio = entry.prio;
    if (policy.discard) begin
      policy.fwdMask = 3'b000;
    end else if (policy.override) begin
      policy.fwdMask = portMask & ~portDisabled; // see RULE9
    end else begin
      policy.fwdMask = portMask & portForwarding & ~portDisabled;
    end
  end
endmodule

// >>> src/atr_table_readout.sv
// register bank that scans the lookup table and reads entries back
// assumes the table answers a read one cycle after tblRdEn
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/10ps
module atr_table_readout
  import atr_pkg::*;
#(
  parameter int TBL_DEPTH = TBL_DEPTH_DEF
) (
  input wire logic clk_sys,
  input wire logic arst_n,
  input atr_bus_req_t regReq,
  output logic [31:0] rdData,
  output logic irq,
  output logic tblRdEn,
  output logic [$clog2(TBL_DEPTH)-1:0] tblRdAddr,
  input atr_entry_t tblRdData,
  input wire logic lkHit,
  input atr_entry_t lkEntry,
  input wire logic [2:0] portDisabled,
  input wire logic [2:0] portForwarding,
  output logic polValid,
  output atr_policy_t policy
);
  localparam int IDXW = $clog2(TBL_DEPTH);
  localparam int POSW = IDXW + 1;
  localparam logic [POSW-1:0] END_POS = POSW'(TBL_DEPTH);
  localparam logic [POSW-1:0] LAST_POS = POSW'(TBL_DEPTH - 1);

  typedef struct packed {
    atr_state_t state;
    logic [POSW-1:0] pos;
    logic [31:0] rdLo;
    logic [HI_ATTR_W-1:0] rdHiAttr;
    logic valid;
    logic eot;
    logic [IRQ_W-1:0] sts;
    logic [IRQ_W-1:0] msk;
    logic daPrio;
    logic [31:0] rdData;
    logic irq;
    logic tblEn;
    logic [IDXW-1:0] tblAddr;
    logic polValid;
    atr_policy_t pol;
  } atr_ro_state_t;

  atr_ro_state_t st_r;
  atr_ro_state_t st_nxt;
  atr_policy_t lkPol;
  logic cmdWr;
  logic scanFirst;
  logic scanGo;
  logic foundEv;
  logic eotEv;
  logic [POSW-1:0] startPos;
  logic [POSW-1:0] posInc;
  logic [IRQ_W-1:0] stsClr;
  logic [31:0] rdHigh;

  atr_entry_decode u_dec (
    .entry(lkEntry),
    .daPrioEn(st_r.daPrio),
    .portDisabled(portDisabled),
    .portForwarding(portForwarding),
    .policy(lkPol)
  );

  always_comb begin
    st_nxt = st_r;
    st_nxt.tblEn = 1'b0;
    foundEv = 1'b0;
    eotEv = 1'b0;
    // commands during a scan are dropped; software polls the busy bit
    cmdWr = regReq.wr && (regReq.addr == ADDR_CMD) && (st_r.state == ST_IDLE);
    scanFirst = cmdWr && regReq.wdata[CMD_FIRST_BIT];
    scanGo = scanFirst || (cmdWr && regReq.wdata[CMD_NEXT_BIT]);
    startPos = scanFirst ? '0 : st_r.pos; // see RULE17
    posInc = st_r.pos + 1'b1;
    case (st_r.state)
      ST_IDLE: begin
        if (scanGo) begin
          st_nxt.valid = 1'b0; // see RULE6
          st_nxt.eot = 1'b0;
          if (startPos >= END_POS) begin
            // resumed past the last slot: nothing left to return
            st_nxt.eot = 1'b1; // see RULE5
            eotEv = 1'b1;
          end else begin
            st_nxt.pos = startPos;
            st_nxt.tblEn = 1'b1;
            st_nxt.tblAddr = startPos[IDXW-1:0];
            st_nxt.state = ST_WAIT;
          end
        end
      end
      ST_WAIT: begin
        st_nxt.state = ST_CHECK;
      end
      ST_CHECK: begin
        if (tblRdData.used) begin
          st_nxt.rdLo = tblRdData.macLo; // see RULE1 RULE3
          st_nxt.rdHiAttr = {tblRdData.age1Ovr, tblRdData.isStatic, tblRdData.age0Flt,
            tblRdData.prioEn, tblRdData.prio, tblRdData.portCode,
            tblRdData.macHi}; // see RULE2 RULE16
          st_nxt.valid = 1'b1; // see RULE7
          foundEv = 1'b1;
          st_nxt.pos = posInc; // see RULE17
          if (st_r.pos == LAST_POS) begin
            st_nxt.eot = 1'b1; // see RULE5
            eotEv = 1'b1;
          end
          st_nxt.state = ST_IDLE;
        end else if (st_r.pos == LAST_POS) begin
          st_nxt.eot = 1'b1; // see RULE5 RULE7
          eotEv = 1'b1;
          st_nxt.pos = END_POS;
          st_nxt.state = ST_IDLE;
        end else begin
          st_nxt.pos = posInc;
          st_nxt.tblEn = 1'b1;
          st_nxt.tblAddr = posInc[IDXW-1:0];
          st_nxt.state = ST_WAIT;
        end
      end
      default: begin
        st_nxt.state = ST_IDLE;
      end
    endcase

    // sticky events, write one to clear; a new event wins over the clear
    stsClr = '0;
    if (regReq.wr && (regReq.addr == ADDR_IRQ_STS)) begin
      stsClr = regReq.wdata[IRQ_W-1:0];
    end
    st_nxt.sts = st_r.sts & ~stsClr;
    st_nxt.sts[IRQ_FOUND_BIT] = st_nxt.sts[IRQ_FOUND_BIT] | foundEv;
    st_nxt.sts[IRQ_EOT_BIT] = st_nxt.sts[IRQ_EOT_BIT] | eotEv;
    if (regReq.wr && (regReq.addr == ADDR_IRQ_MSK)) begin
      st_nxt.msk = regReq.wdata[IRQ_W-1:0];
    end
    if (regReq.wr && (regReq.addr == ADDR_CFG)) begin
      st_nxt.daPrio = regReq.wdata[CFG_DAPRIO_BIT];
    end
    st_nxt.irq = |(st_nxt.sts & st_nxt.msk);

    // lookup answers registered so the outputs come from flops
    st_nxt.polValid = lkHit;
    st_nxt.pol = lkHit ? lkPol : st_r.pol;

    rdHigh = {4'h0, st_r.eot, st_r.valid, st_r.rdHiAttr}; // see RULE2
    st_nxt.rdData = '0;
    if (regReq.rd) begin
      case (regReq.addr)
        ADDR_RD_LOW: st_nxt.rdData = st_r.rdLo; // see RULE1
        ADDR_RD_HIGH: st_nxt.rdData = rdHigh;
        ADDR_CMD: st_nxt.rdData[CMD_BUSY_BIT] = (st_r.state != ST_IDLE);
        ADDR_IRQ_STS: st_nxt.rdData[IRQ_W-1:0] = st_r.sts;
        ADDR_IRQ_MSK: st_nxt.rdData[IRQ_W-1:0] = st_r.msk;
        ADDR_CFG: st_nxt.rdData[CFG_DAPRIO_BIT] = st_r.daPrio;
        default: st_nxt.rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_r.state <= ST_IDLE;
      st_r.pos <= '0;
      st_r.rdLo <= RD_LOW_RST;
      st_r.rdHiAttr <= RD_HIGH_RST;
      st_r.valid <= 1'b0;
      st_r.eot <= 1'b0;
      st_r.sts <= '0;
      st_r.msk <= IRQ_MSK_RST;
      st_r.daPrio <= CFG_DAPRIO_RST;
      st_r.rdData <= '0;
      st_r.irq <= 1'b0;
      st_r.tblEn <= 1'b0;
      st_r.tblAddr <= '0;
      st_r.polValid <= 1'b0;
      st_r.pol <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdData = st_r.rdData;
  assign irq = st_r.irq;
  assign tblRdEn = st_r.tblEn;
  assign tblRdAddr = st_r.tblAddr;
  assign polValid = st_r.polValid;
  assign policy = st_r.pol;

  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);

  low_word_read_a: assert property ( // see RULE1
    regReq.rd && regReq.addr == ADDR_RD_LOW |=> rdData == $past(st_r.rdLo))
    else $error("low word read mismatch");

  high_word_read_a: assert property ( // see RULE2
    regReq.rd && regReq.addr == ADDR_RD_HIGH
    |=> rdData[HI_VALID_BIT] == $past(st_r.valid) && rdData[HI_EOT_BIT] == $past(st_r.eot)
    && rdData[31:28] == 4'h0)
    else $error("high word read mismatch");

  load_by_scan_a: assert property ( // see RULE3
    $changed(st_r.rdLo) |-> $past(st_r.state) == ST_CHECK)
    else $error("read words changed outside a scan");

  valid_clear_a: assert property ( // see RULE6
    st_r.state == ST_IDLE && regReq.wr && regReq.addr == ADDR_CMD
    && (regReq.wdata[CMD_FIRST_BIT] || regReq.wdata[CMD_NEXT_BIT])
    |=> !st_r.valid ##1 !st_r.valid)
    else $error("valid not cleared by scan command");

  found_sets_valid_a: assert property ( // see RULE7
    st_r.state == ST_CHECK && tblRdData.used |=> st_r.valid && st_r.sts[IRQ_FOUND_BIT])
    else $error("found entry did not set valid");

  table_end_a: assert property ( // see RULE5
    st_r.state == ST_CHECK && st_r.pos == LAST_POS |=> st_r.eot && st_r.state == ST_IDLE)
    else $error("end of table not flagged");

  empty_end_a: assert property ( // see RULE7
    st_r.state == ST_CHECK && !tblRdData.used && st_r.pos == LAST_POS |=> !st_r.valid)
    else $error("valid set without an entry");

  scan_restart_a: assert property ( // see RULE17
    st_r.state == ST_IDLE && regReq.wr && regReq.addr == ADDR_CMD
    && regReq.wdata[CMD_FIRST_BIT] |=> st_r.pos == '0 && tblRdAddr == '0 && tblRdEn)
    else $error("scan first did not restart");

  scan_resume_a: assert property ( // see RULE17
    st_r.state == ST_CHECK && tblRdData.used |=> st_r.pos == $past(st_r.pos) + 1'b1)
    else $error("scan position not advanced");

  filter_drop_a: assert property ( // see RULE12
    lkHit && lkEntry.isStatic && lkEntry.age0Flt |=> polValid && policy.fwdMask == 3'b000)
    else $error("filtered entry forwarded");

  prio_gate_a: assert property ( // see RULE14
    lkHit |=> policy.prioValid == ($past(lkEntry.prioEn) && $past(st_r.daPrio)))
    else $error("priority enable gating wrong");

  override_fwd_a: assert property ( // see RULE9
    lkHit && lkEntry.isStatic && lkEntry.age1Ovr && !lkEntry.age0Flt
    && lkEntry.portCode == 3'b111
    |=> policy.fwdMask == ~$past(portDisabled))
    else $error("override did not bypass port state");

  irq_level_a: assert property (
    $rose(st_r.sts[IRQ_EOT_BIT]) && st_r.msk[IRQ_EOT_BIT] |-> irq)
    else $error("interrupt missing for masked-in event");

  rd_data_idle_a: assert property (
    !regReq.rd |=> rdData == '0)
    else $error("read data not zero outside a read");

  high_attr_read_a: assert property ( // see RULE2
    regReq.rd && regReq.addr == ADDR_RD_HIGH
    |=> rdData[HI_ATTR_W-1:0] == $past(st_r.rdHiAttr))
    else $error("high word attribute read mismatch");

  high_by_scan_a: assert property ( // see RULE3
    $changed(st_r.rdHiAttr) |-> $past(st_r.state) == ST_CHECK)
    else $error("high word changed outside a scan");

  valid_by_scan_a: assert property ( // see RULE7
    $rose(st_r.valid) |-> $past(st_r.state) == ST_CHECK && $past(tblRdData.used))
    else $error("valid set without a found entry");

  eot_at_end_a: assert property ( // see RULE5
    $rose(st_r.eot) |-> $past(st_r.pos) >= LAST_POS)
    else $error("end of table flagged early");

  table_rd_pulse_a: assert property (
    tblRdEn |-> st_r.state == ST_WAIT ##1 !tblRdEn)
    else $error("table read request not a single pulse");

  wait_to_check_a: assert property (
    st_r.state == ST_WAIT |=> st_r.state == ST_CHECK)
    else $error("table answer not checked after wait");

  scan_step_a: assert property ( // see RULE17
    st_r.state == ST_CHECK && !tblRdData.used && st_r.pos != LAST_POS
    |=> tblRdEn && st_r.pos == $past(st_r.pos) + 1'b1 && tblRdAddr == st_r.pos[IDXW-1:0])
    else $error("empty slot did not step the scan");

  next_resumes_a: assert property ( // see RULE17
    st_r.state == ST_IDLE && regReq.wr && regReq.addr == ADDR_CMD
    && regReq.wdata[CMD_NEXT_BIT] && !regReq.wdata[CMD_FIRST_BIT] && st_r.pos < END_POS
    |=> tblRdEn && st_r.pos == $past(st_r.pos))
    else $error("scan next did not resume in place");

  past_end_a: assert property ( // see RULE5 RULE7
    st_r.state == ST_IDLE && regReq.wr && regReq.addr == ADDR_CMD
    && regReq.wdata[CMD_NEXT_BIT] && !regReq.wdata[CMD_FIRST_BIT] && st_r.pos == END_POS
    |=> st_r.eot && !st_r.valid && !tblRdEn && st_r.state == ST_IDLE)
    else $error("scan past the end not flagged");

  mask_write_a: assert property (
    regReq.wr && regReq.addr == ADDR_IRQ_MSK |=> st_r.msk == $past(regReq.wdata[IRQ_W-1:0]))
    else $error("mask write not taken");

  cfg_write_a: assert property (
    regReq.wr && regReq.addr == ADDR_CFG
    |=> st_r.daPrio == $past(regReq.wdata[CFG_DAPRIO_BIT]))
    else $error("config write not taken");

  sts_clear_a: assert property (
    regReq.wr && regReq.addr == ADDR_IRQ_STS && !foundEv && !eotEv
    |=> (st_r.sts & $past(regReq.wdata[IRQ_W-1:0])) == '0)
    else $error("status bit not cleared by write one");

  eot_sets_sts_a: assert property ( // see RULE5
    eotEv |=> st_r.eot && st_r.sts[IRQ_EOT_BIT])
    else $error("end of table event lost");

  irq_match_a: assert property (
    irq == |(st_r.sts & st_r.msk))
    else $error("interrupt level out of step with status");

  pol_valid_pulse_a: assert property (
    polValid == $past(lkHit))
    else $error("policy valid not one cycle after a hit");

  policy_hold_a: assert property (
    !lkHit |=> $stable(policy))
    else $error("policy changed without a hit");

  code_reserved_a: assert property ( // see RULE15
    lkHit && lkEntry.portCode == 3'h3 |=> policy.fwdMask == 3'h0)
    else $error("reserved port code forwarded");

  age_exempt_a: assert property ( // see RULE10
    lkHit |=> policy.ageExempt == $past(lkEntry.isStatic))
    else $error("aging exemption wrong");

  age_timer_a: assert property ( // see RULE8 RULE11
    lkHit && !lkEntry.isStatic
    |=> policy.ageTimer == {$past(lkEntry.age1Ovr), $past(lkEntry.age0Flt)})
    else $error("aging timer bits wrong");

  prio_pass_a: assert property ( // see RULE14
    lkHit |=> policy.prio == $past(lkEntry.prio))
    else $error("entry priority not passed on");

  low_word_load_a: assert property ( // see RULE1
    st_r.state == ST_CHECK && tblRdData.used |=> st_r.rdLo == $past(tblRdData.macLo))
    else $error("low word not loaded from entry");

  mac_tail_load_a: assert property ( // see RULE16
    st_r.state == ST_CHECK && tblRdData.used
    |=> st_r.rdHiAttr[15:0] == $past(tblRdData.macHi))
    else $error("last address bits not loaded");
endmodule

// >>> tb/atr_table_readout_tb.sv
// bench for the table entry readout bank: register reads, scans, irq and lookup policy
// assumes atr_pkg and atr_table_readout compiled first; bench models the table memory
`timescale 1ns/10ps
module atr_table_readout_tb
  import atr_pkg::*;
;
  localparam int DEPTH = 8;
  localparam logic [2:0] PMAP [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
  logic clk_sys = 1'h0;
  logic arst_n = 1'h0;
  atr_bus_req_t req = '0;
  logic [31:0] rdData;
  logic irq;
  logic tblRdEn;
  logic polValid;
  logic lkHit = 1'h0;
  logic [2:0] tblRdAddr;
  logic [2:0] portDisabled = 3'h0;
  logic [2:0] portForwarding = 3'h0;
  atr_entry_t tblRdData = '0;
  atr_entry_t lkEntry = '0;
  atr_entry_t e;
  atr_policy_t policy;
  atr_entry_t mem [DEPTH];
  int errTotal = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] val;

  atr_table_readout #(.TBL_DEPTH(DEPTH)) dut_u (.clk_sys(clk_sys), .arst_n(arst_n),
    .regReq(req), .rdData(rdData), .irq(irq), .tblRdEn(tblRdEn), .tblRdAddr(tblRdAddr),
    .tblRdData(tblRdData), .lkHit(lkHit), .lkEntry(lkEntry), .portDisabled(portDisabled),
    .portForwarding(portForwarding), .polValid(polValid), .policy(policy));

  always #2.5 clk_sys = ~clk_sys;

  // memory answers a cycle after the request; idle cycles toggle so stale data shows
  always @(posedge clk_sys) begin
    if (tblRdEn) begin
      tblRdData <= mem[tblRdAddr];
    end else begin
      tblRdData <= ~tblRdData;
    end
  end

  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 4000) begin
      errTotal++;
      finalReport();
    end
  end

  task automatic finalReport();
    $display("checks %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      errTotal++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'h1;
    @(posedge clk_sys);
    req.wr <= 1'h0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    req.addr <= a;
    req.rd <= 1'h1;
    @(posedge clk_sys);
    req.rd <= 1'h0;
    #1;
    d = rdData;
  endtask

  task automatic rdchk(input string what, input logic [15:0] a, input logic [31:0] exp,
                       input logic [31:0] m);
    rd(a, val);
    chk(what, exp & m, val & m);
  endtask

  // bounded poll on busy; a hung scan shows up as a busy mismatch
  task automatic scan(input int bitNo);
    int n;
    n = 0;
    wr(ADDR_CMD, 32'h0000_0001 << bitNo);
    do begin
      rd(ADDR_CMD, val);
      n++;
    end while (val[CMD_BUSY_BIT] !== 1'h0 && n < 40);
    chk("busy", 32'h0000_0000, {31'h0, val[CMD_BUSY_BIT]});
  endtask

  task automatic entry_chk(input atr_entry_t x, input logic eot, input logic vld);
    rdchk("low word", ADDR_RD_LOW, x.macLo, 32'hFFFF_FFFF);
    rdchk("high word", ADDR_RD_HIGH, {4'h0, eot, vld, x[57:32]}, 32'hFFFF_FFFF);
  endtask

  task automatic look(input atr_entry_t x, input logic [2:0] expMask, input logic expPv);
    @(posedge clk_sys);
    lkHit <= 1'h1;
    lkEntry <= x;
    @(posedge clk_sys);
    lkHit <= 1'h0;
    #1;
    chk("pol valid", 32'h0000_0001, {31'h0, polValid});
    chk("fwd mask", {29'h0, expMask}, {29'h0, policy.fwdMask});
    chk("prio valid", {31'h0, expPv}, {31'h0, policy.prioValid});
    chk("prio", {29'h0, x.prio}, {29'h0, policy.prio});
    chk("static bits", {29'h0, x.isStatic, x.isStatic & x.age1Ovr, x.isStatic & x.age0Flt},
        {29'h0, policy.ageExempt, policy.override, policy.discard});
    if (!x.isStatic) begin
      chk("age timer", {30'h0, x.age1Ovr, x.age0Flt}, {30'h0, policy.ageTimer});
    end
  endtask

  initial begin
    for (int i = 0; i < DEPTH; i++) begin
      mem[i] = '0;
      mem[i].macLo = 32'h5555_5555;
    end
    mem[2] = {1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 3'h5, 3'h4, 16'hA1B2, 32'h1234_5679};
    mem[5] = {1'h1, 1'h1, 1'h1, 1'h1, 1'h0, 3'h2, 3'h7, 16'hFFFF, 32'h8000_0000};
    mem[7] = {1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 3'h7, 3'h3, 16'h0001, 32'hFFFF_FFFE};
    repeat (20) @(posedge clk_sys);
    arst_n <= 1'h1;
    rdchk("low reset", ADDR_RD_LOW, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("high reset", ADDR_RD_HIGH, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("mask reset", ADDR_IRQ_MSK, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("cfg reset", ADDR_CFG, 32'h0000_0000, 32'hFFFF_FFFF);
    rdchk("unmapped", 16'h1800, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(ADDR_RD_LOW, 32'hFFFF_FFFF);
    rdchk("low after write", ADDR_RD_LOW, 32'h0000_0000, 32'hFFFF_FFFF);
    $display("test registers done");
    scan(CMD_FIRST_BIT);
    entry_chk(mem[2], 1'h0, 1'h1);
    rdchk("found sts", ADDR_IRQ_STS, 32'h0000_0001, 32'h0000_0001);
    chk("irq masked", 32'h0000_0000, {31'h0, irq});
    wr(ADDR_IRQ_MSK, 32'h0000_0003);
    rd(ADDR_IRQ_MSK, val);
    chk("irq unmasked", 32'h0000_0001, {31'h0, irq});
    wr(ADDR_IRQ_STS, 32'h0000_0003);
    rdchk("sts cleared", ADDR_IRQ_STS, 32'h0000_0000, 32'h0000_0003);
    chk("irq cleared", 32'h0000_0000, {31'h0, irq});
    scan(CMD_NEXT_BIT);
    entry_chk(mem[5], 1'h0, 1'h1);
    scan(CMD_NEXT_BIT);
    entry_chk(mem[7], 1'h1, 1'h1);
    chk("irq eot", 32'h0000_0001, {31'h0, irq});
    rdchk("eot sts", ADDR_IRQ_STS, 32'h0000_0003, 32'h0000_0003);
    scan(CMD_NEXT_BIT);
    rdchk("past end", ADDR_RD_HIGH, 32'h0800_0000, 32'h0C00_0000);
    scan(CMD_FIRST_BIT);
    entry_chk(mem[2], 1'h0, 1'h1);
    // both bits: first wins; the next command lands mid-scan and is dropped
    wr(ADDR_CMD, 32'h0000_0003);
    scan(CMD_NEXT_BIT);
    entry_chk(mem[2], 1'h0, 1'h1);
    $display("test scan done");
    wr(ADDR_CFG, 32'h0000_0001);
    portForwarding <= 3'h6;
    portDisabled <= 3'h1;
    for (int c = 0; c < 8; c++) begin
      e = '0;
      e.used = 1'h1;
      e.portCode = c[2:0];
      e.prioEn = c[0];
      e.prio = c[2:0];
      e.age1Ovr = c[1];
      e.age0Flt = c[2];
      look(e, PMAP[c] & 3'h6, c[0]);
    end
    portForwarding <= 3'h0;
    portDisabled <= 3'h2;
    e = {1'h1, 1'h1, 1'h1, 1'h0, 1'h1, 3'h3, 3'h7, 16'h0000, 32'h0000_0000};
    look(e, 3'h5, 1'h1);
    e = {1'h1, 1'h0, 1'h1, 1'h1, 1'h0, 3'h1, 3'h7, 16'h0000, 32'h0000_0000};
    look(e, 3'h0, 1'h0);
    wr(ADDR_CFG, 32'h0000_0000);
    e = {1'h1, 1'h1, 1'h0, 1'h1, 1'h1, 3'h6, 3'h2, 16'h0000, 32'h0000_0000};
    look(e, 3'h0, 1'h0);
    $display("test lookup done");
    finalReport();
  end
endmodule
